// [design/bpm_pkg.sv]
package bpm_pkg;

    // Register word offsets on the fieldbus register map
    localparam logic [15:0] ACT_SRC_OFS   = 16'h0fd2;
    localparam logic [15:0] STATE_OFS     = 16'h0fd4;
    localparam logic [15:0] INSTANTANEOUS_RELEASE_OFS      = 16'h1b5d;
    localparam logic [15:0] POS_OFS       = 16'h4ec0;
    localparam logic [15:0] PROTO_A_OFS   = 16'ha41f;
    localparam logic [15:0] PROTO_B_OFS   = 16'ha807;
    localparam logic [15:0] CMD_OFS       = 16'hf619;

    // Ground-fault pairs: pickup at index i, delay beside it
    localparam int GF_N = 8;
    localparam logic [GF_N-1:0][15:0] GF_PK_OFS = {
        16'h2f24, 16'h2f14, 16'h2efc, 16'h2ee4,
        16'h2b30, 16'h2b24, 16'h2b10, 16'h2afc
    };
    localparam logic [GF_N-1:0][15:0] GF_DL_OFS = {
        16'h2f26, 16'h2f16, 16'h2efe, 16'h2ee6,
        16'h2b32, 16'h2b26, 16'h2b12, 16'h2afe
    };

    // Position codes
    localparam logic [2:0] POS_CONNECTED    = 3'h0;
    localparam logic [2:0] POS_TEST         = 3'h1;
    localparam logic [2:0] POS_DISCONNECTED = 3'h2;
    localparam logic [2:0] POS_MAINT        = 3'h3;
    localparam logic [2:0] POS_INTERMEDIATE = 3'h4;
    localparam logic [2:0] POS_FIXED        = 3'h5;

    // Activation source register bit positions
    localparam int ASRC_DISPLAY_BIT = 0;
    localparam int ASRC_INPUT_BIT   = 1;
    localparam int ASRC_COM_A_BIT   = 4;
    localparam int ASRC_COM_B_BIT   = 5;
    localparam int ASRC_LIU_BIT     = 9;
    localparam int ASRC_IO1_BIT     = 12;
    localparam int ASRC_TEST_BIT    = 31;

    // Protocol state bits of each comms module
    localparam int PROTO_MODBUS_BIT = 9;
    localparam int PROTO_IE_BIT     = 10;

    // Mode state register bit
    localparam int STATE_ACTIVE_BIT = 0;

    // Switch command values
    localparam logic [15:0] CMD_OFF = 16'h0000;
    localparam logic [15:0] CMD_ON  = 16'h0001;

    // Reset values
    localparam logic [15:0] INSTANTANEOUS_RELEASE_RESET = 16'h0000;
    localparam logic [31:0] GF_RESET   = 32'h0000_0000;

    // Distinct internal activation sources
    typedef enum logic [3:0] {
        SRC_DISPLAY, SRC_INPUT,
        SRC_COM_A_MODBUS, SRC_COM_A_IE,
        SRC_COM_B_MODBUS, SRC_COM_B_IE,
        SRC_LIU_USB, SRC_LIU_BT,
        SRC_IO1, SRC_IO2, SRC_IO3, SRC_IO4, SRC_IO5,
        SRC_TEST
    } bpm_src_t;

    // Raw position contacts of the guide frame
    typedef struct packed {
        logic fixed;
        logic maint;
        logic disconnected;
        logic test;
        logic connected;
    } bpm_pos_t;

    // Register access request
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
        bpm_src_t    src;
    } bpm_bus_req_t;

    // Local mode request
    typedef struct packed {
        logic     valid;
        logic     on;
        bpm_src_t src;
    } bpm_mode_req_t;

endpackage

// [design/bpm_status_regs.sv]
`timescale 1ns/1ns
module bpm_status_regs
    import bpm_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire bpm_pos_t      pos_in,
    input  wire logic [2:0]    gf_variant,
    input  wire bpm_mode_req_t mode_req,
    input  wire bpm_bus_req_t  bus,
    output logic               bus_ack,
    output logic               bus_err,
    output logic [15:0]        bus_rdata,
    output logic               maint_active,
    output logic [15:0]        maint_instantaneous_release_pickup,
    output logic [31:0]        maint_gf_pickup,
    output logic [31:0]        maint_gf_delay
);

    typedef struct packed {
        bpm_pos_t              pos_s1;
        bpm_pos_t              pos_s2;
        logic [2:0]            pos_code;
        logic                  active;
        bpm_src_t              src;
        logic [15:0]           instantaneous_release;
        logic [GF_N-1:0][31:0] gpk;
        logic [GF_N-1:0][31:0] gdl;
        logic                  ack;
        logic                  err;
        logic [15:0]           rdata;
        logic                  o_active;
        logic [15:0]           o_instantaneous_release;
        logic [31:0]           o_pk;
        logic [31:0]           o_dl;
    } bpm_state_t;

    bpm_state_t q;
    bpm_state_t next_q;

    // Activation register image for one internal source
    function automatic logic [31:0] src_mask(input bpm_src_t s);
        logic [31:0] m;
        m = 32'h0000_0000;
        case (s)
            SRC_DISPLAY:      m[ASRC_DISPLAY_BIT] = 1'b1;
            SRC_INPUT:        m[ASRC_INPUT_BIT] = 1'b1;
            SRC_COM_A_MODBUS: m[ASRC_COM_A_BIT] = 1'b1;
            SRC_COM_A_IE:     m[ASRC_COM_A_BIT] = 1'b1;
            SRC_COM_B_MODBUS: m[ASRC_COM_B_BIT] = 1'b1;
            SRC_COM_B_IE:     m[ASRC_COM_B_BIT] = 1'b1;
            SRC_LIU_USB:      m[ASRC_LIU_BIT] = 1'b1;
            SRC_LIU_BT:       m[ASRC_LIU_BIT] = 1'b1;
            SRC_IO1:          m[ASRC_IO1_BIT] = 1'b1;
            SRC_IO2:          m[ASRC_IO1_BIT + 1] = 1'b1;
            SRC_IO3:          m[ASRC_IO1_BIT + 2] = 1'b1;
            SRC_IO4:          m[ASRC_IO1_BIT + 3] = 1'b1;
            SRC_IO5:          m[ASRC_IO1_BIT + 4] = 1'b1;
            SRC_TEST:         m[ASRC_TEST_BIT] = 1'b1;
            default:          m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    // Protocol state word of one comms module
    function automatic logic [15:0] proto_word(input logic act, input bpm_src_t s,
                                               input bpm_src_t mb, input bpm_src_t ie);
        logic [15:0] w;
        w = 16'h0000;
        w[PROTO_MODBUS_BIT] = act && (s == mb);
        w[PROTO_IE_BIT]     = act && (s == ie);
        return w;
    endfunction

    logic [31:0] act_src_word;
    logic        cmd_hit;
    logic        req_on;
    logic        req_go;
    bpm_src_t    req_src;
    logic        hit;

    // Activation register image, empty while mode is off
    assign act_src_word = q.active ? src_mask(q.src) : 32'h0000_0000;

    always_comb begin
        next_q = q;
        hit     = 1'b0;
        cmd_hit = 1'b0;
        req_on  = 1'b0;
        req_go  = 1'b0;
        req_src = SRC_DISPLAY;

        // Two-stage synchroniser for the frame contacts
        next_q.pos_s1 = pos_in;
        next_q.pos_s2 = q.pos_s1;

        // Position encoding, fixed-mounted overriding the rest
        if (q.pos_s2.fixed) begin
            next_q.pos_code = POS_FIXED;
        end else begin
            case ({q.pos_s2.maint, q.pos_s2.disconnected, q.pos_s2.test,
                   q.pos_s2.connected})
                4'h1:    next_q.pos_code = POS_CONNECTED;
                4'h2:    next_q.pos_code = POS_TEST;
                4'h4:    next_q.pos_code = POS_DISCONNECTED;
                4'h8:    next_q.pos_code = POS_MAINT;
                default: next_q.pos_code = POS_INTERMEDIATE;
            endcase
        end

        // Bus answer defaults
        next_q.ack   = 1'b0;
        next_q.err   = 1'b0;
        next_q.rdata = 16'h0000;

        // Register access; 32-bit values sit high word first
        if (bus.req) begin
            next_q.ack = 1'b1;
            case (bus.addr)
                ACT_SRC_OFS: begin
                    hit = !bus.we;
                    next_q.rdata = act_src_word[31:16];
                end
                ACT_SRC_OFS + 16'h0001: begin
                    hit = !bus.we;
                    next_q.rdata = act_src_word[15:0];
                end
                STATE_OFS: begin
                    hit = !bus.we;
                    next_q.rdata[STATE_ACTIVE_BIT] = q.active;
                end
                POS_OFS: begin
                    hit = !bus.we;
                    next_q.rdata = {13'h0000, q.pos_code};
                end
                PROTO_A_OFS: begin
                    hit = !bus.we;
                    next_q.rdata = proto_word(q.active, q.src, SRC_COM_A_MODBUS,
                                              SRC_COM_A_IE);
                end
                PROTO_B_OFS: begin
                    hit = !bus.we;
                    next_q.rdata = proto_word(q.active, q.src, SRC_COM_B_MODBUS,
                                              SRC_COM_B_IE);
                end
                INSTANTANEOUS_RELEASE_OFS: begin
                    hit = 1'b1;
                    next_q.rdata = q.instantaneous_release;
                    if (bus.we) begin
                        next_q.instantaneous_release = bus.wdata;
                    end
                end
                CMD_OFS: begin
                    hit = bus.we && (bus.wdata == CMD_ON || bus.wdata == CMD_OFF);
                    cmd_hit = hit;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase

            // Ground-fault settings table
            for (int i = 0; i < GF_N; i++) begin
                if (bus.addr == GF_PK_OFS[i]) begin
                    hit = 1'b1;
                    next_q.rdata = q.gpk[i][31:16];
                    if (bus.we) next_q.gpk[i][31:16] = bus.wdata;
                end
                if (bus.addr == GF_PK_OFS[i] + 16'h0001) begin
                    hit = 1'b1;
                    next_q.rdata = q.gpk[i][15:0];
                    if (bus.we) next_q.gpk[i][15:0] = bus.wdata;
                end
                if (bus.addr == GF_DL_OFS[i]) begin
                    hit = 1'b1;
                    next_q.rdata = q.gdl[i][31:16];
                    if (bus.we) next_q.gdl[i][31:16] = bus.wdata;
                end
                if (bus.addr == GF_DL_OFS[i] + 16'h0001) begin
                    hit = 1'b1;
                    next_q.rdata = q.gdl[i][15:0];
                    if (bus.we) next_q.gdl[i][15:0] = bus.wdata;
                end
            end
        end

        // Pick the mode request: bus command first, local path otherwise
        if (cmd_hit) begin
            req_go  = 1'b1;
            req_on  = (bus.wdata == CMD_ON);
            req_src = bus.src;
        end else if (mode_req.valid) begin
            req_go  = 1'b1;
            req_on  = mode_req.on;
            req_src = mode_req.src;
        end

        // Mode switching with owner check
        if (req_go) begin
            if (req_on && !q.active) begin
                next_q.active = 1'b1;
                next_q.src    = req_src;
            end else if (!req_on && q.active && req_src == q.src) begin
                next_q.active = 1'b0;
            end else if (cmd_hit) begin
                next_q.err = 1'b1;
            end
        end

        if (bus.req && !hit) begin
            next_q.err = 1'b1;
        end

        // Settings copied to the outputs every cycle, whether the mode is on or off
        next_q.o_active = q.active;
        next_q.o_instantaneous_release   = q.instantaneous_release;
        next_q.o_pk     = q.gpk[gf_variant];
        next_q.o_dl     = q.gdl[gf_variant];
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q          <= '0;
            q.src      <= SRC_DISPLAY;
            q.pos_code <= POS_INTERMEDIATE;
            q.instantaneous_release     <= INSTANTANEOUS_RELEASE_RESET;
            q.gpk      <= {GF_N{GF_RESET}};
            q.gdl      <= {GF_N{GF_RESET}};
            q.o_instantaneous_release   <= INSTANTANEOUS_RELEASE_RESET;
            q.o_pk     <= GF_RESET;
            q.o_dl     <= GF_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign bus_ack           = q.ack;
    assign bus_err           = q.err;
    assign bus_rdata         = q.rdata;
    assign maint_active      = q.o_active;
    assign maint_instantaneous_release_pickup = q.o_instantaneous_release;
    assign maint_gf_pickup   = q.o_pk;
    assign maint_gf_delay    = q.o_dl;

endmodule

// [sim/bpm_master_model.sv]
`timescale 1ns/1ns
module bpm_master_model
    import bpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        bus_ack,
    input  wire logic        bus_err,
    input  wire logic [15:0] bus_rdata,
    output bpm_bus_req_t     bus
);
    initial bus = '0;
    // One access: request for one edge, answer taken just after that same edge
    // Only the source that switched the mode on can switch it off again
    task automatic acc(input logic we, input logic [15:0] a, input logic [15:0] d,
                       input bpm_src_t s, output logic [17:0] r);
        bus = '{1'b1, we, a, d, s};
        @(posedge clk);
        #1;
        r = {bus_ack, bus_err, bus_rdata};
        bus = '{1'b0, we, ~a, ~d, s};
        @(posedge clk);
        #1;
    endtask
endmodule

// [sim/bpm_status_regs_assertions.sv]
`timescale 1ns/1ns
module bpm_status_regs_assertions
    import bpm_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_b,
    input wire bpm_pos_t     pos_in,
    input wire bpm_bus_req_t bus,
    input wire logic         bus_ack,
    input wire logic         bus_err,
    input wire logic [15:0]  bus_rdata,
    input wire logic         maint_active,
    input wire logic [15:0]  maint_instantaneous_release_pickup
);
    logic [2:0] up;
    wire        rd = bus.req && !bus.we;
    wire        wr = bus.req && bus.we;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Edges since reset release, so position checks skip the sync warm-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    a_ack_next: assert property (bus.req |=> bus_ack)
        else $error("no ack after request");
    a_idle_quiet: assert property (!bus.req |=> !bus_ack && bus_rdata == 16'h0)
        else $error("answer without request");
    a_unmapped_err: assert property (bus.req && bus.addr == 16'h1234 |=> bus_err)
        else $error("unmapped access not refused");
    a_ro_write: assert property (wr && bus.addr == STATE_OFS |=> bus_err)
        else $error("write to state register not refused");
    a_state_read: assert property (
        rd && bus.addr == STATE_OFS |=> bus_rdata[0] == maint_active)
        else $error("state read differs from mode");
    a_cmd_on: assert property (
        (wr && bus.addr == CMD_OFS && bus.wdata == CMD_ON) ##1 !bus_err |=> maint_active)
        else $error("accepted on command did not activate");
    a_cmd_off: assert property (
        (wr && bus.addr == CMD_OFS && bus.wdata == CMD_OFF) ##1 !bus_err |=> !maint_active)
        else $error("accepted off command did not deactivate");
    a_pos_fixed: assert property (
        ($stable(pos_in) && up == 3'h7)[*4] ##0 (rd && bus.addr == POS_OFS && pos_in.fixed)
        |=> bus_rdata == 16'h0005)
        else $error("fixed contact not reported as code 5");
    a_pos_between: assert property (
        ($stable(pos_in) && up == 3'h7)[*4] ##0
        (rd && bus.addr == POS_OFS && !pos_in.fixed && $countones(pos_in) != 1)
        |=> bus_rdata == 16'h0004)
        else $error("unresolved position not code 4");
    a_instantaneous_release_out: assert property (
        wr && bus.addr == INSTANTANEOUS_RELEASE_OFS |=> ##1 maint_instantaneous_release_pickup == $past(bus.wdata, 2))
        else $error("pickup output not updated");
endmodule

// [sim/test_breaker_position_maintenance_status.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_breaker_position_maintenance_status
    import bpm_pkg::*;
;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    bpm_pos_t      pos_in = '0;
    logic [2:0]    gf_variant = 3'h0;
    bpm_mode_req_t mode_req = '0;
    bpm_bus_req_t  bus;
    logic          bus_ack, bus_err, maint_active;
    logic [15:0]   bus_rdata, maint_instantaneous_release_pickup;
    logic [31:0]   maint_gf_pickup, maint_gf_delay;
    int            n_errors = 0;
    int            checks_done = 0;
    bpm_src_t      ls [10] = '{SRC_DISPLAY, SRC_INPUT, SRC_LIU_USB, SRC_LIU_BT, SRC_IO1,
                               SRC_IO2, SRC_IO3, SRC_IO4, SRC_IO5, SRC_TEST};
    int            lb [10] = '{0, 1, 9, 9, 12, 13, 14, 15, 16, 31};
    logic [7:0][4:0] pv = {5'h00, 5'h03, 5'h1f, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    logic [7:0][2:0] pc = {3'h4, 3'h4, 3'h5, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
    always #10 clk = ~clk;
    bpm_status_regs bpm_status_regs_instantaneous_release (.clk(clk), .rst_b(rst_b), .pos_in(pos_in),
        .gf_variant(gf_variant), .mode_req(mode_req), .bus(bus), .bus_ack(bus_ack),
        .bus_err(bus_err), .bus_rdata(bus_rdata), .maint_active(maint_active),
        .maint_instantaneous_release_pickup(maint_instantaneous_release_pickup), .maint_gf_pickup(maint_gf_pickup),
        .maint_gf_delay(maint_gf_delay));
    bpm_master_model bpm_master_model_instantaneous_release (.clk(clk), .bus_ack(bus_ack), .bus_err(bus_err),
        .bus_rdata(bus_rdata), .bus(bus));
    // One access with expected error flag and read data
    task automatic rw(input logic we, input logic [15:0] a, input logic [15:0] d,
                      input bpm_src_t s, input logic e, input logic [15:0] x);
        logic [17:0] r;
        bpm_master_model_instantaneous_release.acc(we, a, d, s, r);
        `CHK(r, {1'b1, e, x})
    endtask
    // Local mode request pulse
    task automatic mq(input logic on, input bpm_src_t s);
        mode_req = '{1'b1, on, s};
        @(posedge clk);
        #1;
        mode_req.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Activation register, high word then low word
    task automatic act(input logic [31:0] x);
        rw(0, ACT_SRC_OFS, 16'h0, SRC_TEST, 0, x[31:16]);
        rw(0, ACT_SRC_OFS + 16'h1, 16'h0, SRC_TEST, 0, x[15:0]);
    endtask
    task automatic results;
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rw(0, 16'h1234, 16'h0, SRC_TEST, 1, 16'h0);
        rw(1, STATE_OFS, 16'h1, SRC_TEST, 1, 16'h0);
        rw(0, CMD_OFS, 16'h0, SRC_TEST, 1, 16'h0);
        rw(1, CMD_OFS, 16'h7, SRC_TEST, 1, 16'h0);
        rw(0, STATE_OFS, 16'h0, SRC_TEST, 0, 16'h0);
        act(32'h0);
        for (int i = 0; i < 8; i++) begin
            pos_in = pv[i];
            repeat (5) @(posedge clk);
            #1;
            rw(0, POS_OFS, 16'h0, SRC_TEST, 0, {13'h0, pc[i]});
        end
        rw(1, CMD_OFS, CMD_ON, SRC_COM_A_MODBUS, 0, 16'h0);
        rw(0, STATE_OFS, 16'h0, SRC_TEST, 0, 16'h1);
        act(32'h0000_0010);
        rw(0, PROTO_A_OFS, 16'h0, SRC_TEST, 0, 16'h0200);
        rw(0, PROTO_B_OFS, 16'h0, SRC_TEST, 0, 16'h0);
        rw(1, CMD_OFS, CMD_ON, SRC_COM_A_MODBUS, 1, 16'h0);
        rw(1, CMD_OFS, CMD_OFF, SRC_COM_A_IE, 1, 16'h0);
        mq(0, SRC_DISPLAY);
        act(32'h0000_0010);
        rw(0, STATE_OFS, 16'h0, SRC_TEST, 0, 16'h1);
        rw(1, CMD_OFS, CMD_OFF, SRC_COM_A_MODBUS, 0, 16'h0);
        act(32'h0);
        rw(1, CMD_OFS, CMD_ON, SRC_COM_B_IE, 0, 16'h0);
        rw(0, PROTO_B_OFS, 16'h0, SRC_TEST, 0, 16'h0400);
        act(32'h0000_0020);
        rw(1, CMD_OFS, CMD_OFF, SRC_COM_B_IE, 0, 16'h0);
        for (int i = 0; i < 10; i++) begin
            mq(1, ls[i]);
            act(32'h1 << lb[i]);
            mq(0, ls[i] == SRC_LIU_USB ? SRC_LIU_BT : SRC_LIU_USB);
            `CHK(maint_active, 1'b1)
            mq(0, ls[i]);
            `CHK(maint_active, 1'b0)
        end
        rw(1, INSTANTANEOUS_RELEASE_OFS, 16'h1234, SRC_COM_A_MODBUS, 0, 16'h0);
        rw(0, INSTANTANEOUS_RELEASE_OFS, 16'h0, SRC_TEST, 0, 16'h1234);
        `CHK(maint_instantaneous_release_pickup, 16'h1234)
        for (int i = 0; i < 8; i++) begin
            rw(1, GF_PK_OFS[i], 16'(i + 1), SRC_TEST, 0, 16'h0);
            rw(1, GF_PK_OFS[i] + 16'h1, 16'h00f0, SRC_TEST, 0, 16'h0);
            rw(1, GF_DL_OFS[i] + 16'h1, 16'(i + 16), SRC_TEST, 0, 16'h0);
            rw(1, GF_DL_OFS[i], 16'(i + 32), SRC_TEST, 0, 16'h0);
            rw(0, GF_DL_OFS[i], 16'h0, SRC_TEST, 0, 16'(i + 32));
        end
        for (int i = 0; i < 8; i++) begin
            gf_variant = 3'(i);
            repeat (2) @(posedge clk);
            #1;
            `CHK(maint_gf_pickup, {16'(i + 1), 16'h00f0})
            `CHK(maint_gf_delay, {16'(i + 32), 16'(i + 16)})
        end
        results();
    end
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #40000;
        n_errors++;
        results();
    end
endmodule
bind bpm_status_regs bpm_status_regs_assertions bpm_status_regs_assertions_instantaneous_release (
    .clk(clk), .rst_b(rst_b), .pos_in(pos_in), .bus(bus), .bus_ack(bus_ack),
    .bus_err(bus_err), .bus_rdata(bus_rdata), .maint_active(maint_active),
    .maint_instantaneous_release_pickup(maint_instantaneous_release_pickup));
